/* File: ocd_cfg.svh */
// opcode decoder constants: field positions, fixed codes, reset values
// assumes inclusion by the decoder package users only
`ifndef OCD_CFG_SVH
`define OCD_CFG_SVH
`define OCD_ROW_MSB 7
`define OCD_ROW_LSB 4
`define OCD_COL_MSB 3
`define OCD_COL_LSB 0
`define OCD_COL_BRA_ACC 4'h3
`define OCD_COL_BRA_ZP 4'h7
`define OCD_COL_BIT_ACC 4'hB
`define OCD_COL_BIT_ZP 4'hF
`define OCD_OP_WAIT 8'hC2
`define OCD_OP_JSR_ZPIND 8'h02
`define OCD_OP_JMP_ZPIND 8'hB2
`define OCD_OP_JSR_SPECIAL 8'h22
`define OCD_ZERO_PAGE 8'h00
`define OCD_SPECIAL_PAGE 8'hFF
`define OCD_SP_RESET 8'hFF
`define OCD_PS_RESET 8'h04
`define OCD_FLAG_C 0
`define OCD_FLAG_Z 1
`define OCD_FLAG_I 2
`define OCD_FLAG_D 3
`define OCD_FLAG_B 4
`define OCD_FLAG_T 5
`define OCD_FLAG_V 6
`define OCD_FLAG_N 7
`endif

/* File: ocd_pkg.sv */
// types shared by the opcode decoder and its address former
// assumes ocd_cfg.svh supplies the numeric constants
`default_nettype none
package ocd_pkg;
   typedef enum logic [3:0] {
      ocd_k_none, ocd_k_branch_if_bit_set, ocd_k_branch_if_bit_clear,
      ocd_k_set_single_bit, ocd_k_clear_single_bit, ocd_k_wait,
      ocd_k_other, ocd_k_undefined
   } ocd_kind_t;
   typedef enum logic [2:0] {
      ocd_a_none, ocd_a_abs, ocd_a_page_zero, ocd_a_stack, ocd_a_ind_x,
      ocd_a_special_page, ocd_a_zp_ind
   } ocd_amode_t;
   typedef struct packed {
      ocd_kind_t kind;
      ocd_amode_t amode;
      logic mem_bit; // bit op targets zero-page byte, not accumulator
      logic [2:0] bit_idx;
   } ocd_dec_t;
   typedef struct packed {
      logic [7:0] addr_high_byte;
      logic [7:0] addr_low_byte;
   } ocd_addr_t;
   typedef enum logic [1:0] {
      ocd_s_run = 2'h0, ocd_s_wait = 2'h1
   } ocd_state_t;
endpackage
`default_nettype wire

/* File: ocd_addr.sv */
// effective address former: high byte joined with low byte
// assumes mode and sources come from the decoder on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "ocd_cfg.svh"
module ocd_addr (
   // mode and sources
   input wire ocd_pkg::ocd_amode_t amode,
   input wire logic [7:0] operand_lo,
   input wire logic [7:0] operand_hi,
   input wire logic [7:0] index_x,
   input wire logic [7:0] stack_ptr,
   // formed address
   output ocd_pkg::ocd_addr_t addr
);
   // select high and low address bytes per mode
   always_comb begin
      addr.addr_high_byte = operand_hi;
      addr.addr_low_byte = operand_lo;
      case (amode)
         ocd_pkg::ocd_a_page_zero, ocd_pkg::ocd_a_zp_ind: begin
            addr.addr_high_byte = `OCD_ZERO_PAGE;
         end
         ocd_pkg::ocd_a_stack: begin
            addr.addr_high_byte = `OCD_ZERO_PAGE;
            addr.addr_low_byte = stack_ptr;
         end
         ocd_pkg::ocd_a_ind_x: begin
            addr.addr_high_byte = `OCD_ZERO_PAGE;
            addr.addr_low_byte = index_x;
         end
         ocd_pkg::ocd_a_special_page: begin
            addr.addr_high_byte = `OCD_SPECIAL_PAGE;
         end
         default: begin
            addr.addr_high_byte = operand_hi;
         end
      endcase
   end
endmodule
`default_nettype wire

/* File: ocd_core.sv */
// opcode decoder with program counter halves, status flags, wait state
// assumes opcode and operand bytes arrive with a one-cycle strobe
// Contract
// - upper nibble row, lower nibble column
// - column 3: accumulator bit branch
// - column 7: zero-page bit branch
// - column B: set/clear accumulator bit
// - column F: set/clear zero-page bit
// - bit index covers positions 0 to 7
// - program counter as two byte halves
// - address is high byte, low byte
// - zero page forces high byte 00
// - stack and X-indirect use register address
// - status holds X-modified arithmetic flag
// - special-page one-byte subroutine call
// - zero-page indirect jump and call
// - decimal mode marks N, V, Z undefined
// - wait stops until timer X terminal
`timescale 1ns/1ps
`default_nettype none
`include "ocd_cfg.svh"
module ocd_core (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // instruction stream
   input wire logic op_valid,
   input wire logic [7:0] opcode,
   input wire logic [7:0] operand_lo,
   input wire logic [7:0] operand_hi,
   input wire logic [7:0] index_x,
   input wire logic timer_x_terminal,
   // program counter halves
   input wire logic pc_high_load,
   input wire logic pc_low_load,
   input wire logic [7:0] pc_load_byte,
   // status flag updates
   input wire logic flags_load,
   input wire logic [7:0] flags_in,
   // decoded results
   output ocd_pkg::ocd_dec_t dec,
   output ocd_pkg::ocd_addr_t addr,
   output logic [7:0] pc_high_byte,
   output logic [7:0] pc_low_byte,
   output logic [7:0] status,
   output logic nvz_undefined,
   output logic clock_stopped
);
   ocd_pkg::ocd_dec_t next_dec;
   ocd_pkg::ocd_state_t state, next_state;
   logic [7:0] next_pc_high_byte, next_pc_low_byte, next_status;
   logic [7:0] stack_ptr;

   // row/column lookup of one opcode
   function automatic ocd_pkg::ocd_dec_t decode(input logic [7:0] op);
      logic [3:0] row;
      logic [3:0] col;
      ocd_pkg::ocd_dec_t d;
      row = op[`OCD_ROW_MSB:`OCD_ROW_LSB];
      col = op[`OCD_COL_MSB:`OCD_COL_LSB];
      d.kind = ocd_pkg::ocd_k_other;
      d.amode = ocd_pkg::ocd_a_none;
      d.mem_bit = 1'b0;
      d.bit_idx = row[3:1];
      case (col)
         `OCD_COL_BRA_ACC, `OCD_COL_BRA_ZP: begin
            d.kind = row[0] ? ocd_pkg::ocd_k_branch_if_bit_clear
                            : ocd_pkg::ocd_k_branch_if_bit_set;
            d.mem_bit = (col == `OCD_COL_BRA_ZP);
            d.amode = d.mem_bit ? ocd_pkg::ocd_a_page_zero
                                : ocd_pkg::ocd_a_none;
         end
         `OCD_COL_BIT_ACC, `OCD_COL_BIT_ZP: begin
            d.kind = row[0] ? ocd_pkg::ocd_k_clear_single_bit
                            : ocd_pkg::ocd_k_set_single_bit;
            d.mem_bit = (col == `OCD_COL_BIT_ZP);
            d.amode = d.mem_bit ? ocd_pkg::ocd_a_page_zero
                                : ocd_pkg::ocd_a_none;
         end
         4'h4, 4'hC: begin
            // odd rows empty except row b and one row per column
            if (row[0] && row != 4'hB && row != (col[3] ? 4'h3 : 4'h9))
               d.kind = ocd_pkg::ocd_k_undefined;
            if (row == 4'h0)
               d.kind = ocd_pkg::ocd_k_undefined;
            d.amode = col[3] ? ocd_pkg::ocd_a_abs : ocd_pkg::ocd_a_page_zero;
            // the load-immediate-to-memory slot is zero-page
            if (col[3] && row == 4'h3)
               d.amode = ocd_pkg::ocd_a_page_zero;
         end
         4'h5, 4'h6: begin
            d.amode = ocd_pkg::ocd_a_page_zero;
         end
         4'h1: begin
            d.amode = ocd_pkg::ocd_a_ind_x;
         end
         4'h2: begin
            case (op)
               `OCD_OP_JSR_ZPIND, `OCD_OP_JMP_ZPIND:
                  d.amode = ocd_pkg::ocd_a_zp_ind;
               `OCD_OP_JSR_SPECIAL:
                  d.amode = ocd_pkg::ocd_a_special_page;
               `OCD_OP_WAIT:
                  d.kind = ocd_pkg::ocd_k_wait;
               8'h52, 8'h72, 8'h92, 8'hD2, 8'hF2:
                  d.kind = ocd_pkg::ocd_k_undefined;
               default:
                  d.amode = ocd_pkg::ocd_a_none;
            endcase
         end
         4'h8: begin
            if (row == 4'h0 || row == 4'h2 || row == 4'h4 || row == 4'h6)
               d.amode = ocd_pkg::ocd_a_stack;
         end
         4'h9: begin
            if (row == 4'h8)
               d.kind = ocd_pkg::ocd_k_undefined;
         end
         4'hA: begin
            if (row == 4'h5 || row == 4'h7 || row == 4'hD || row == 4'hF)
               d.kind = ocd_pkg::ocd_k_undefined;
         end
         4'hE: begin
            if (row == 4'h9)
               d.kind = ocd_pkg::ocd_k_undefined;
            d.amode = ocd_pkg::ocd_a_abs;
         end
         4'hD: begin
            d.amode = ocd_pkg::ocd_a_abs;
         end
         default: begin
            d.amode = ocd_pkg::ocd_a_none;
         end
      endcase
      return d;
   endfunction

   // stack pointer fixed at reset value in this block
   assign stack_ptr = `OCD_SP_RESET;

   // next decode, pc halves, flags and wait state
   always_comb begin
      next_dec = dec;
      next_state = state;
      next_pc_high_byte = pc_high_byte;
      next_pc_low_byte = pc_low_byte;
      next_status = status;
      if (pc_high_load)
         next_pc_high_byte = pc_load_byte;
      if (pc_low_load)
         next_pc_low_byte = pc_load_byte;
      if (flags_load)
         next_status = flags_in;
      case (state)
         ocd_pkg::ocd_s_run: begin
            if (op_valid) begin
               next_dec = decode(opcode);
               if (next_dec.kind == ocd_pkg::ocd_k_wait)
                  next_state = ocd_pkg::ocd_s_wait;
            end
         end
         ocd_pkg::ocd_s_wait: begin
            if (timer_x_terminal)
               next_state = ocd_pkg::ocd_s_run;
         end
         default: begin
            next_state = ocd_pkg::ocd_s_run;
         end
      endcase
   end

   // register decode and architectural halves
   always_ff @(posedge clk) begin
      if (srst) begin
         dec <= '0;
         state <= ocd_pkg::ocd_s_run;
         pc_high_byte <= 8'h00;
         pc_low_byte <= 8'h00;
         status <= `OCD_PS_RESET;
      end else begin
         dec <= next_dec;
         state <= next_state;
         pc_high_byte <= next_pc_high_byte;
         pc_low_byte <= next_pc_low_byte;
         status <= next_status;
      end
   end

   // decimal mode makes arithmetic N, V, Z undefined
   assign nvz_undefined = status[`OCD_FLAG_D];
   assign clock_stopped = (state == ocd_pkg::ocd_s_wait);

   ocd_addr u_addr (
      .amode(dec.amode),
      .operand_lo(operand_lo),
      .operand_hi(operand_hi),
      .index_x(index_x),
      .stack_ptr(stack_ptr),
      .addr(addr)
   );

   property p_bbs_decode;
      @(posedge clk) disable iff (srst)
      (op_valid && state == ocd_pkg::ocd_s_run && opcode[3:0] == 4'h3
       && !opcode[4]) |=> (dec.kind == ocd_pkg::ocd_k_branch_if_bit_set
       && dec.bit_idx == $past(opcode[7:5]) && !dec.mem_bit);
   endproperty
   a_bbs_decode: assert property (p_bbs_decode)
      else $error("accumulator bit branch decoded wrong");

   property p_bbc_zp;
      @(posedge clk) disable iff (srst)
      (op_valid && state == ocd_pkg::ocd_s_run && opcode[3:0] == 4'h7
       && opcode[4]) |=> (dec.kind == ocd_pkg::ocd_k_branch_if_bit_clear
       && dec.mem_bit && addr.addr_high_byte == 8'h00);
   endproperty
   a_bbc_zp: assert property (p_bbc_zp)
      else $error("zero-page bit branch decoded wrong");

   property p_seb_acc;
      @(posedge clk) disable iff (srst)
      (op_valid && state == ocd_pkg::ocd_s_run && opcode[3:0] == 4'hB)
      |=> (dec.kind == ($past(opcode[4]) ? ocd_pkg::ocd_k_clear_single_bit
           : ocd_pkg::ocd_k_set_single_bit));
   endproperty
   a_seb_acc: assert property (p_seb_acc)
      else $error("accumulator set/clear bit decoded wrong");

   property p_seb_zp;
      @(posedge clk) disable iff (srst)
      (op_valid && state == ocd_pkg::ocd_s_run && opcode[3:0] == 4'hF)
      |=> (dec.mem_bit && dec.bit_idx == $past(opcode[7:5]));
   endproperty
   a_seb_zp: assert property (p_seb_zp)
      else $error("zero-page set/clear bit decoded wrong");

   property p_pc_half;
      @(posedge clk) disable iff (srst)
      (pc_high_load && !pc_low_load) |=>
      (pc_high_byte == $past(pc_load_byte) && $stable(pc_low_byte));
   endproperty
   a_pc_half: assert property (p_pc_half)
      else $error("program counter halves not independent");

   property p_stack_addr;
      @(posedge clk) disable iff (srst)
      (dec.amode == ocd_pkg::ocd_a_stack) |->
      (addr.addr_low_byte == stack_ptr && addr.addr_high_byte == 8'h00);
   endproperty
   a_stack_addr: assert property (p_stack_addr)
      else $error("stack address not from stack pointer");

   sequence s_wait_taken;
      op_valid && state == ocd_pkg::ocd_s_run && opcode == 8'hC2;
   endsequence
   property p_wait;
      @(posedge clk) disable iff (srst)
      s_wait_taken ##1 !timer_x_terminal |-> clock_stopped;
   endproperty
   a_wait: assert property (p_wait)
      else $error("wait did not stop the clock");

   property p_wake;
      @(posedge clk) disable iff (srst)
      (clock_stopped && timer_x_terminal) |=> !clock_stopped;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wait did not end on timer terminal");

   property p_undef;
      @(posedge clk) disable iff (srst)
      (op_valid && state == ocd_pkg::ocd_s_run && opcode == 8'h89)
      |=> dec.kind == ocd_pkg::ocd_k_undefined;
   endproperty
   a_undef: assert property (p_undef)
      else $error("unassigned opcode not undefined");
endmodule
`default_nettype wire

/* File: ocd_mem.sv */
// data memory model seen through the decoder's formed address
// assumes a combinational read; contents are a fixed address pattern
`timescale 1ns/1ps
`default_nettype none
module ocd_mem (
   // address from the decoder
   input wire ocd_pkg::ocd_addr_t addr,
   // read data
   output logic [7:0] rdata
);
   // each location holds its address bytes folded with a fixed mask
   assign rdata = addr.addr_high_byte ^ addr.addr_low_byte ^ 8'h5a;
endmodule
`default_nettype wire

/* File: tb_ocd_core.sv */
// self-checking bench for the opcode decoder core
// assumes a 50 ns clock and the data memory model on the address
`timescale 1ns/1ps
`default_nettype none
`include "ocd_cfg.svh"
module tb_ocd_core;
   typedef struct packed {
      ocd_pkg::ocd_dec_t d;
      logic [2:0] m;
   } ocd_exp_t;
   logic clk, srst, op_valid, timer_x_terminal;
   logic pc_high_load, pc_low_load, flags_load;
   logic [7:0] opcode, operand_lo, operand_hi, index_x;
   logic [7:0] pc_load_byte, flags_in, r1, r2, rdata;
   logic [7:0] pc_high_byte, pc_low_byte, status;
   logic [3:0] rr, cc, k;
   logic nvz_undefined, clock_stopped;
   ocd_pkg::ocd_dec_t dec;
   ocd_pkg::ocd_addr_t addr;
   ocd_exp_t notes[$];
   ocd_exp_t e;
   int n_mismatch = 0;
   int samples_checked = 0;
   integer seed = 30282;

   ocd_core i_ocd_core (.clk(clk), .srst(srst), .op_valid(op_valid),
      .opcode(opcode), .operand_lo(operand_lo), .operand_hi(operand_hi),
      .index_x(index_x), .timer_x_terminal(timer_x_terminal),
      .pc_high_load(pc_high_load), .pc_low_load(pc_low_load),
      .pc_load_byte(pc_load_byte), .flags_load(flags_load),
      .flags_in(flags_in), .dec(dec), .addr(addr),
      .pc_high_byte(pc_high_byte), .pc_low_byte(pc_low_byte),
      .status(status), .nvz_undefined(nvz_undefined),
      .clock_stopped(clock_stopped));
   ocd_mem i_ocd_mem (.addr(addr), .rdata(rdata));

   task automatic chk(input string nm, input logic [15:0] ex,
                      input logic [15:0] got);
      samples_checked++;
      if (got !== ex) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // drive one opcode with random operands; mode 7 means not expected
   task automatic send(input logic [7:0] op, input logic [2:0] m,
      input logic [3:0] kd, input logic [2:0] am, input logic mb,
      input logic [2:0] ix);
      ocd_exp_t x;
      x.d = ocd_pkg::ocd_dec_t'({kd, am, mb, ix});
      x.m = m;
      @(posedge clk);
      op_valid <= 1'b1;
      opcode <= op;
      operand_lo <= 8'($random(seed));
      operand_hi <= 8'($random(seed));
      index_x <= 8'($random(seed));
      if (m != 3'h7) notes.push_back(x);
   endtask

   task automatic report_and_stop;
      if (notes.size() != 0) n_mismatch++;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // monitor: each taken opcode retires the oldest note
   always @(posedge clk) begin
      if (!srst && op_valid && !clock_stopped) begin
         #1;
         if (notes.size() == 0) begin
            chk("queue", 16'h0001, 16'h0000);
         end else begin
            e = notes.pop_front();
            if (e.m < 3) chk("kind", 16'(e.d.kind), 16'(dec.kind));
            if (e.m == 1 || e.m == 2) begin
               chk("bit_idx", 16'(e.d.bit_idx), 16'(dec.bit_idx));
               chk("mem_bit", 16'(e.d.mem_bit), 16'(dec.mem_bit));
            end
            if (e.m >= 2)
               chk("amode", 16'(e.d.amode), 16'(dec.amode));
            if (e.m == 2) chk("zp addr", {8'h00, operand_lo}, addr);
            if (e.m == 3) chk("sp addr", {8'hff, operand_lo}, addr);
            if (e.m == 4)
               chk("zpi rd", 16'(operand_lo ^ 8'h5a), 16'(rdata));
            if (e.m == 5)
               chk("abs addr", {operand_hi, operand_lo}, addr);
            if (e.m == 6 && e.d.amode == ocd_pkg::ocd_a_stack)
               chk("stk addr", {8'h00, `OCD_SP_RESET}, addr);
            if (e.m == 6 && e.d.amode == ocd_pkg::ocd_a_ind_x)
               chk("x addr", {8'h00, index_x}, addr);
         end
      end
   end

   // clock generation
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      report_and_stop;
   end

   // main sequence
   initial begin
      {srst, op_valid, timer_x_terminal} = 3'b100;
      {pc_high_load, pc_low_load, flags_load} = 3'b000;
      {opcode, operand_lo, operand_hi, index_x} = 32'h0000_0000;
      {pc_load_byte, flags_in} = 16'h0000;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk("dec rst", 16'h0000, 16'(dec));
      chk("status rst", 16'(`OCD_PS_RESET), 16'(status));
      chk("pc rst", 16'h0000, {pc_high_byte, pc_low_byte});
      chk("stop rst", 16'h0000, 16'(clock_stopped));
      $display("test reset done");
      // every bit column and row, back to back
      for (int r = 0; r < 16; r++) begin
         for (int j = 0; j < 4; j++) begin
            rr = 4'(r);
            cc = 4'(4 * j + 3);
            if (cc[3])
               k = rr[0] ? ocd_pkg::ocd_k_clear_single_bit
                         : ocd_pkg::ocd_k_set_single_bit;
            else
               k = rr[0] ? ocd_pkg::ocd_k_branch_if_bit_clear
                         : ocd_pkg::ocd_k_branch_if_bit_set;
            send({rr, cc}, cc[2] ? 3'h2 : 3'h1, k,
               ocd_pkg::ocd_a_page_zero, cc[2], rr[3:1]);
         end
      end
      send(8'h04, 3'h0, ocd_pkg::ocd_k_undefined, 3'h0, 1'b0, 3'h0);
      send(8'h34, 3'h0, ocd_pkg::ocd_k_undefined, 3'h0, 1'b0, 3'h0);
      send(8'h9c, 3'h0, ocd_pkg::ocd_k_undefined, 3'h0, 1'b0, 3'h0);
      send(8'h89, 3'h0, ocd_pkg::ocd_k_undefined, 3'h0, 1'b0, 3'h0);
      send(8'h3c, 3'h0, ocd_pkg::ocd_k_other, 3'h0, 1'b0, 3'h0);
      send(8'h52, 3'h0, ocd_pkg::ocd_k_undefined, 3'h0, 1'b0, 3'h0);
      send(8'h22, 3'h3, 4'h0,
         ocd_pkg::ocd_a_special_page, 1'b0, 3'h0);
      send(8'h02, 3'h4, 4'h0, ocd_pkg::ocd_a_zp_ind, 1'b0, 3'h0);
      send(8'hb2, 3'h4, 4'h0,
         ocd_pkg::ocd_a_zp_ind, 1'b0, 3'h0);
      send(8'had, 3'h5, 4'h0, ocd_pkg::ocd_a_abs, 1'b0, 3'h0);
      send(8'h48, 3'h6, 4'h0, ocd_pkg::ocd_a_stack, 1'b0, 3'h0);
      send(8'h81, 3'h6, 4'h0, ocd_pkg::ocd_a_ind_x, 1'b0, 3'h0);
      $display("test decode done");
      // wait stops, ignores an opcode, resumes on terminal count
      send(8'hc2, 3'h0, ocd_pkg::ocd_k_wait, 3'h0, 1'b0, 3'h0);
      send(8'h03, 3'h7, 4'h0, 3'h0, 1'b0, 3'h0);
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      chk("stopped", 16'h0001, 16'(clock_stopped));
      chk("held kind", 16'(ocd_pkg::ocd_k_wait), 16'(dec.kind));
      @(posedge clk);
      timer_x_terminal <= 1'b1;
      @(posedge clk);
      timer_x_terminal <= 1'b0;
      #1;
      chk("resumed", 16'h0000, 16'(clock_stopped));
      $display("test wait done");
      // program counter halves loaded one at a time
      r1 = 8'($random(seed));
      r2 = 8'($random(seed));
      @(posedge clk);
      pc_high_load <= 1'b1;
      pc_load_byte <= r1;
      @(posedge clk);
      pc_high_load <= 1'b0;
      pc_low_load <= 1'b1;
      pc_load_byte <= r2;
      @(posedge clk);
      pc_low_load <= 1'b0;
      #1;
      chk("pc", {r1, r2}, {pc_high_byte, pc_low_byte});
      $display("test pc done");
      // status with the x-modified flag and decimal on then off
      for (int i = 0; i < 2; i++) begin
         r1 = 8'($random(seed)) | 8'h20;
         r1[3] = ~i[0];
         @(posedge clk);
         flags_load <= 1'b1;
         flags_in <= r1;
         @(posedge clk);
         flags_load <= 1'b0;
         #1;
         chk("status", 16'(r1), 16'(status));
         chk("nvz undef", 16'(r1[3]), 16'(nvz_undefined));
      end
      $display("test status done");
      report_and_stop;
   end
endmodule
`default_nettype wire
